/* logic/cgf_map.svh */
// Register indices, field positions, reset values and codes of the clock gate block
`ifndef CGF_MAP_SVH
`define CGF_MAP_SVH

// ----------------------------------------------------------------------
// Register indices on the internal register port
// ----------------------------------------------------------------------
`define CGF_IDX_GATE      2'h0
`define CGF_IDX_MISC      2'h1
`define CGF_IDX_STS       2'h2

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define CGF_GATE_RST      16'h0000
`define CGF_GATE_WR_MASK  16'h007F
`define CGF_MISC_RST      16'h0005
`define CGF_ZERO16        16'h0000

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define CGF_STS_FO1_BIT   15
`define CGF_STS_FO0_BIT   14

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define CGF_BANK_FO_IN0   2'h1
`define CGF_BANK_FO_IN1   2'h2
`define CGF_IN1_EXCL_BANK 6
`define CGF_START_NO_HOLD 2'h2
`define CGF_START_HOLD    2'h0
`define CGF_GRP_IGNORE    3'h7
`define CGF_GRP_W         3
`define CGF_FO_W          2
`define CGF_SRC_IN0       0
`define CGF_SRC_IN1       1

`endif

/* logic/cgf_pkg.sv */
// Types shared by the clock gate and fan-out control block
package cgf_pkg;

    // Fan-out buffer mode of one clock input
    typedef enum logic [1:0] {
        CGF_FO_OFF    = 2'b00,
        CGF_FO_AUTO   = 2'b01,
        CGF_FO_RSV    = 2'b10,
        CGF_FO_MANUAL = 2'b11
    } cgf_fo_mode_e;

    // Clock gating register layout
    typedef struct packed {
        logic [8:0] rsv_ro;      // Always zero
        logic       rsv_rw;      // Stored, no effect
        logic [4:0] mon_gate;    // Monitor 4..0 gates
        logic       nvm_gate;    // Memory interface gate
    } cgf_gate_s;

    // Miscellaneous configuration register layout
    typedef struct packed {
        logic [4:0]   rsv_hi;    // Stored, no effect
        logic         los_sel;   // Loss-of-signal measuring clock
        cgf_fo_mode_e fo1_mode;  // Input one fan-out mode
        logic [1:0]   startup;   // Output hold until lock
        logic         ssc_share; // Spread-spectrum phase share
        cgf_fo_mode_e fo0_mode;  // Input zero fan-out mode
        logic [2:0]   rsv_lo;    // Stored, no effect
    } cgf_misc_s;

    // Edge latch state of one fan-out input
    typedef struct packed {
        logic prev_n;            // Last sampled reset pin
        logic pick;              // Latched fan-out choice
    } cgf_lat_s;

endpackage

/* logic/cgf_fanout_latch.sv */
// Fan-out choice latch for one clock input, taken at the reset pin's rising edge
`timescale 1ns/1ps
`include "cgf_map.svh"

module cgf_fanout_latch
    import cgf_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire cgf_fo_mode_e mode,
    input  wire logic         pin_n,   // Reset pin, choice taken at its rise
    input  wire logic         los,
    output logic              status
);

    cgf_lat_s st_reg;   // Registered state
    cgf_lat_s st_next;  // Next state

    // ----------------------------------------------------------------------
    // Next state and live status
    // ----------------------------------------------------------------------
    always_comb begin
        st_next        = st_reg;
        st_next.prev_n = pin_n;
        // Choice only moves on a rising edge while automatic
        if (mode == CGF_FO_AUTO && pin_n && !st_reg.prev_n) begin
            st_next.pick = !los;
        end
        case (mode)
            CGF_FO_MANUAL: status = 1'b1;
            CGF_FO_AUTO:   status = st_reg.pick;
            default:       status = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    auto_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == CGF_FO_AUTO && pin_n && !st_reg.prev_n)
        |=> (st_reg.pick == !$past(los)))
        else $error("fan-out choice not latched on reset edge");
    auto_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == CGF_FO_AUTO && !(pin_n && !st_reg.prev_n))
        |=> $stable(st_reg.pick))
        else $error("fan-out choice moved without reset edge");

endmodule

/* logic/cgf_clock_gate_ctl.sv */
// Clock gating, loss-of-signal clock select, fan-out and startup output control
`timescale 1ns/1ps
`include "cgf_map.svh"

module cgf_clock_gate_ctl
    import cgf_pkg::*;
#(
    parameter int NUM_BANK = 8,
    parameter int NUM_OUT  = 12,
    parameter int SRC_W    = 3
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic                      reg_wr,
    input  wire logic [1:0]                reg_addr,
    input  wire logic [15:0]               reg_wdata,
    output logic      [15:0]               reg_rdata,
    input  wire logic                      startup_active,
    input  wire logic                      apll_lock,
    input  wire logic                      los_zero,
    input  wire logic                      los_one,
    input  wire logic                      pcie_reset_zero_n,
    input  wire logic                      pcie_reset_one_n,
    input  wire logic [NUM_OUT*3-1:0]      out_dis_group,
    input  wire logic [NUM_BANK*2-1:0]     bank_fanout_mode,
    input  wire logic [NUM_BANK*SRC_W-1:0] bank_src_cfg,
    output logic      [4:0]                monitor_gate,
    output logic                           nvm_interface_gate,
    output logic                           los_clk_sel,
    output logic                           ssc_phase_share,
    output logic                           input_zero_fanout_status,
    output logic                           input_one_fanout_status,
    output logic      [NUM_OUT-1:0]        out_drv_en,
    output logic      [NUM_BANK*SRC_W-1:0] bank_src
);

    // ----------------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------------
    if (NUM_BANK < 1 || NUM_OUT < 1 || SRC_W < 2) begin : g_bad_param
        $error("cgf_clock_gate_ctl: unsupported parameter values");
    end

    // Whole module state in one word
    typedef struct packed {
        cgf_gate_s                 gate;   // Clock gating register
        cgf_misc_s                 misc;   // Miscellaneous configuration
        logic                      fo0;    // Input zero fan-out status
        logic                      fo1;    // Input one fan-out status
        logic [NUM_OUT-1:0]        drv;    // Output driver enables
        logic [NUM_BANK*SRC_W-1:0] src;    // Per-bank source codes
        logic [15:0]               rdata;  // Read data
    } cgf_top_s;

    // Source codes that banks read as clock input zero and one
    localparam logic [SRC_W-1:0] SRC_IN0 = SRC_W'(`CGF_SRC_IN0); // Input zero code
    localparam logic [SRC_W-1:0] SRC_IN1 = SRC_W'(`CGF_SRC_IN1); // Input one code

    cgf_top_s st_reg;    // Registered state
    cgf_top_s st_next;   // Next state
    logic     fo0_live;  // Input zero status, combinational
    logic     fo1_live;  // Input one status, combinational

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    // Driver enable: held off only during startup, before lock, unless exempt
    function automatic logic drv_pick(input logic [1:0] start, input logic busy,
                                      input logic lock, input logic [2:0] grp);
        drv_pick = !busy || (start == `CGF_START_NO_HOLD) || lock
                   || (grp == `CGF_GRP_IGNORE);
    endfunction

    // Bank source: fan-out overrides the configured source when active, except input one on bank six
    function automatic logic [SRC_W-1:0] bank_pick(input int b, input logic [1:0] fm,
                                                   input logic [SRC_W-1:0] cfg,
                                                   input logic s0, input logic s1);
        if (fm == `CGF_BANK_FO_IN0 && s0) begin
            bank_pick = SRC_IN0;
        end else if (fm == `CGF_BANK_FO_IN1 && s1 && b != `CGF_IN1_EXCL_BANK) begin
            bank_pick = SRC_IN1;
        end else begin
            bank_pick = cfg;
        end
    endfunction

    // ----------------------------------------------------------------------
    // Fan-out edge latches, one per clock input
    // ----------------------------------------------------------------------
    // Latches only move in automatic mode; other modes keep the last choice
    cgf_fanout_latch u_fo0 (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .mode    (st_reg.misc.fo0_mode),
        .pin_n   (pcie_reset_zero_n),
        .los     (los_zero),
        .status  (fo0_live)
    );

    cgf_fanout_latch u_fo1 (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .mode    (st_reg.misc.fo1_mode),
        .pin_n   (pcie_reset_one_n),
        .los     (los_one),
        .status  (fo1_live)
    );

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    // Register port timing: a write taken at edge N shows on the register
    // outputs after N; status, driver enables and read data follow one edge
    // later and bank sources one more. The extra stages keep every pin
    // straight from a flop, at the price of two cycles of latency.
    // Reads need no strobe: read data tracks the address every cycle.
    always_comb begin
        st_next = st_reg;
        // Register writes; read-only gate bits stay zero
        // Reserved misc fields keep what is written; software keeps defaults
        if (reg_wr) begin
            case (reg_addr)
                `CGF_IDX_GATE: begin
                    st_next.gate = cgf_gate_s'(reg_wdata & `CGF_GATE_WR_MASK);
                end
                `CGF_IDX_MISC: begin
                    st_next.misc = cgf_misc_s'(reg_wdata);
                end
                default: begin
                end
            endcase
        end
        // Status follows the mode and the latched choice
        st_next.fo0 = fo0_live;
        st_next.fo1 = fo1_live;
        // Startup driver hold with per-output exemption
        for (int i = 0; i < NUM_OUT; i++) begin
            st_next.drv[i] = drv_pick(st_reg.misc.startup, startup_active, apll_lock,
                                      out_dis_group[i*`CGF_GRP_W +: `CGF_GRP_W]);
        end
        // Bank sources from fan-out status or the bank configuration
        for (int b = 0; b < NUM_BANK; b++) begin
            st_next.src[b*SRC_W +: SRC_W] =
                bank_pick(b, bank_fanout_mode[b*`CGF_FO_W +: `CGF_FO_W],
                          bank_src_cfg[b*SRC_W +: SRC_W], st_reg.fo0, st_reg.fo1);
        end
        // Read data, one cycle after the address; unmapped reads zero
        case (reg_addr)
            `CGF_IDX_GATE: st_next.rdata = st_reg.gate;
            `CGF_IDX_MISC: st_next.rdata = st_reg.misc;
            `CGF_IDX_STS: begin
                st_next.rdata = `CGF_ZERO16;
                st_next.rdata[`CGF_STS_FO1_BIT] = st_reg.fo1;
                st_next.rdata[`CGF_STS_FO0_BIT] = st_reg.fo0;
            end
            default:       st_next.rdata = `CGF_ZERO16;
        endcase
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    // Drivers start disabled so nothing glitches out before the first update
    // Bank sources start at code zero until the first update as well
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg.gate  <= cgf_gate_s'(`CGF_GATE_RST);
            st_reg.misc  <= cgf_misc_s'(`CGF_MISC_RST);
            st_reg.fo0   <= 1'b0;
            st_reg.fo1   <= 1'b0;
            st_reg.drv   <= '0;
            st_reg.src   <= '0;
            st_reg.rdata <= `CGF_ZERO16;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------------
    assign reg_rdata                = st_reg.rdata;
    assign monitor_gate             = st_reg.gate.mon_gate;
    assign nvm_interface_gate       = st_reg.gate.nvm_gate;
    assign los_clk_sel              = st_reg.misc.los_sel;
    assign ssc_phase_share          = st_reg.misc.ssc_share;
    assign input_zero_fanout_status = st_reg.fo0;
    assign input_one_fanout_status  = st_reg.fo1;
    assign out_drv_en               = st_reg.drv;
    assign bank_src                 = st_reg.src;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    mon_gate_wr_a: assert property (
        (reg_wr && reg_addr == `CGF_IDX_GATE) |=> monitor_gate == $past(reg_wdata[5:1]))
        else $error("monitor gates do not follow write");

    nvm_gate_wr_a: assert property (
        (reg_wr && reg_addr == `CGF_IDX_GATE) |=> nvm_interface_gate == $past(reg_wdata[0]))
        else $error("memory gate does not follow write");

    los_sel_wr_a: assert property (
        (reg_wr && reg_addr == `CGF_IDX_MISC) |=> los_clk_sel == $past(reg_wdata[10]))
        else $error("measuring clock select does not follow write");

    // Fan-out status, one edge after the mode register
    in1_off_a: assert property (
        (st_reg.misc.fo1_mode == CGF_FO_OFF) |=> !input_one_fanout_status)
        else $error("input one status set while off");

    in1_manual_a: assert property (
        (st_reg.misc.fo1_mode == CGF_FO_MANUAL) |=> input_one_fanout_status)
        else $error("input one status clear while manual");

    in0_off_a: assert property (
        (st_reg.misc.fo0_mode == CGF_FO_OFF) |=> !input_zero_fanout_status)
        else $error("input zero status set while off");

    in0_manual_a: assert property (
        (st_reg.misc.fo0_mode == CGF_FO_MANUAL) |=> input_zero_fanout_status)
        else $error("input zero status clear while manual");

    // Bank sources, one edge after the status; bank six never takes input
    // one, so the last bank stands in for the input one side
    bank0_in0_a: assert property (
        (bank_fanout_mode[1:0] == `CGF_BANK_FO_IN0 && input_zero_fanout_status)
        |=> bank_src[SRC_W-1:0] == SRC_IN0)
        else $error("bank zero not fed from input zero");

    bank_in1_a: assert property (
        (NUM_BANK - 1 != `CGF_IN1_EXCL_BANK
         && bank_fanout_mode[NUM_BANK*`CGF_FO_W-1 -: `CGF_FO_W] == `CGF_BANK_FO_IN1
         && input_one_fanout_status) |=> bank_src[NUM_BANK*SRC_W-1 -: SRC_W] == SRC_IN1)
        else $error("last bank not fed from input one");

    // Driver enables; output zero and the last output stand in for all
    startup_hold_a: assert property (
        (startup_active && !apll_lock && st_reg.misc.startup == `CGF_START_HOLD
         && out_dis_group[2:0] != `CGF_GRP_IGNORE) |=> !out_drv_en[0])
        else $error("output enabled before lock");

    rsv_hold_a: assert property (
        (startup_active && !apll_lock && st_reg.misc.startup != `CGF_START_NO_HOLD
         && out_dis_group[2:0] != `CGF_GRP_IGNORE) |=> !out_drv_en[0])
        else $error("output enabled under a holding startup code");

    drv_free_a: assert property (
        !startup_active |=> out_drv_en[0])
        else $error("output held off outside startup");

    drv_nohold_a: assert property (
        (st_reg.misc.startup == `CGF_START_NO_HOLD) |=> out_drv_en[0])
        else $error("output held off although lock is ignored");

    drv_lock_a: assert property (
        apll_lock |=> out_drv_en[0])
        else $error("output held off after lock");

    group_ignore_a: assert property (
        (out_dis_group[NUM_OUT*`CGF_GRP_W-1 -: `CGF_GRP_W] == `CGF_GRP_IGNORE)
        |=> out_drv_en[NUM_OUT-1])
        else $error("exempt output held off");

    // Register side
    ssc_share_wr_a: assert property (
        (reg_wr && reg_addr == `CGF_IDX_MISC) |=> ssc_phase_share == $past(reg_wdata[5]))
        else $error("phase share does not follow write");

    status_mode_a: assert property (
        input_zero_fanout_status |-> $past(st_reg.misc.fo0_mode) != CGF_FO_OFF)
        else $error("input zero status without fan-out mode");

    status1_mode_a: assert property (
        input_one_fanout_status |-> $past(st_reg.misc.fo1_mode) != CGF_FO_OFF)
        else $error("input one status without fan-out mode");

    sts_rd_a: assert property (
        (reg_addr == `CGF_IDX_STS)
        |=> reg_rdata[`CGF_STS_FO0_BIT] == $past(input_zero_fanout_status))
        else $error("status register does not show input zero status");

endmodule

/* sim/tb.sv */
// Self-checking testbench of the clock gate and fan-out control block
`timescale 1ns/1ps
`include "cgf_map.svh"

// Compare one design value against its expectation and count the result
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module tb import cgf_pkg::*;;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        mclk;                      // 40 MHz system clock
    logic        rst_b;                     // Async reset, active low
    logic        reg_wr;                    // Register write strobe
    logic [1:0]  reg_addr;                  // Register index
    logic [15:0] reg_wdata;                 // Write data
    logic [15:0] reg_rdata;                 // Registered read data
    logic        startup_active;            // Startup sequence running
    logic        apll_lock;                 // Analog PLL lock
    logic        los_zero;                  // Loss of signal, input zero
    logic        los_one;                   // Loss of signal, input one
    logic        pcie_reset_zero_n;         // Latch strobe for input zero
    logic        pcie_reset_one_n;          // Latch strobe for input one
    logic [35:0] out_dis_group;             // Per-output disable group
    logic [15:0] bank_fanout_mode;          // Per-bank fan-out setting
    logic [23:0] bank_src_cfg;              // Per-bank configured source
    logic [4:0]  monitor_gate;              // Monitor clock stops
    logic        nvm_interface_gate;        // Memory interface clock stop
    logic        los_clk_sel;               // Measuring clock select
    logic        ssc_phase_share;           // Spread phase share
    logic        input_zero_fanout_status;  // Input zero fan-out active
    logic        input_one_fanout_status;   // Input one fan-out active
    logic [11:0] out_drv_en;                // Output driver enables
    logic [23:0] bank_src;                  // Effective bank sources
    int          err_count;                 // Mismatches seen
    int          n_checks;                  // Comparisons made

    cgf_clock_gate_ctl cgf_clock_gate_ctl_i (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .startup_active(startup_active), .apll_lock(apll_lock), .los_zero(los_zero),
        .los_one(los_one), .pcie_reset_zero_n(pcie_reset_zero_n),
        .pcie_reset_one_n(pcie_reset_one_n), .out_dis_group(out_dis_group),
        .bank_fanout_mode(bank_fanout_mode), .bank_src_cfg(bank_src_cfg),
        .monitor_gate(monitor_gate), .nvm_interface_gate(nvm_interface_gate),
        .los_clk_sel(los_clk_sel), .ssc_phase_share(ssc_phase_share),
        .input_zero_fanout_status(input_zero_fanout_status),
        .input_one_fanout_status(input_one_fanout_status), .out_drv_en(out_drv_en),
        .bank_src(bank_src));

    // ------------------------------------------------------------------
    // Clock and expectation helpers
    // ------------------------------------------------------------------
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // Expected bank sources; bank six never follows input one
    function automatic logic [23:0] src_exp(input logic s0, input logic s1);
        logic [23:0] r;
        r = bank_src_cfg;
        for (int b = 0; b < 8; b++) begin
            if (bank_fanout_mode[2*b +: 2] == 2'h1 && s0) r[3*b +: 3] = 3'h0;
            else if (bank_fanout_mode[2*b +: 2] == 2'h2 && s1 && b != 6) r[3*b +: 3] = 3'h1;
        end
        return r;
    endfunction

    // Expected driver enables; reserved startup codes act as hold
    function automatic logic [11:0] drv_exp(input logic act, input logic [1:0] st,
                                            input logic lock);
        logic [11:0] r;
        for (int i = 0; i < 12; i++) begin
            r[i] = !act || st == 2'h2 || lock || out_dis_group[3*i +: 3] == 3'h7;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Access tasks; all stimulus moves on the falling edge
    // ------------------------------------------------------------------
    // Strobe stays up so writes can run back to back; rd or settle drops it
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge mclk);
    endtask

    // Address sampled at the next rising edge, data settled by the falling one
    task automatic rd(input logic [1:0] a, input logic [15:0] e, input string nm);
        reg_wr   = 1'b0;
        reg_addr = a;
        @(negedge mclk);
        `CHK(nm, e, reg_rdata)
    endtask

    task automatic settle(input int n);
        reg_wr = 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    // Status outputs, status register and bank sources in one go
    task automatic chk_fo(input logic s0, input logic s1);
        `CHK("zero status", s0, input_zero_fanout_status)
        `CHK("one status", s1, input_one_fanout_status)
        `CHK("bank sources", src_exp(s0, s1), bank_src)
        rd(2'h2, {s1, s0, 14'h0}, "status reg");
    endtask

    // Reset, outputs quiet while held, defaults after release
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK("drv in reset", 12'h000, out_drv_en)
        `CHK("gate in reset", 5'h00, monitor_gate)
        `CHK("src in reset", 24'h0, bank_src)
        rst_b = 1'b1;
        rd(2'h0, 16'h0000, "gate default");
        rd(2'h1, 16'h0005, "misc default");
    endtask

    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog against a hang
    // ------------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reg_wr, reg_addr, reg_wdata, startup_active, apll_lock} = '0;
        {los_zero, los_one, pcie_reset_zero_n, pcie_reset_one_n} = '0;
        err_count = 0;
        n_checks  = 0;
        // Sources 4..7 so they never look like input codes 0 or 1
        for (int b = 0; b < 8; b++) bank_src_cfg[3*b +: 3] = 3'(b | 4);
        // Outputs three and eleven sit in the lock-exempt group
        for (int i = 0; i < 12; i++) out_dis_group[3*i +: 3] = 3'((i + 4) % 8);
        bank_fanout_mode = 16'hA4C9;        // Mix of settings, bank six on two
        do_reset();
        // Gate register: upper bits read-only, back-to-back writes
        wr(2'h0, 16'hFFFF);
        rd(2'h0, 16'h007F, "gate mask");
        `CHK("all gates", 5'h1F, monitor_gate)
        `CHK("nvm gate on", 1'b1, nvm_interface_gate)
        wr(2'h0, 16'h0021);
        wr(2'h0, 16'h0014);
        rd(2'h0, 16'h0014, "gate b2b");
        for (int k = 0; k < 5; k++) begin
            wr(2'h0, 16'(2 << k));
            rd(2'h0, 16'(2 << k), "gate walk");
            `CHK("monitor gate", 5'(1 << k), monitor_gate)
            `CHK("nvm gate off", 1'b0, nvm_interface_gate)
        end
        wr(2'h0, 16'h0001);
        settle(1);
        `CHK("nvm only", 1'b1, nvm_interface_gate)
        `CHK("no monitor", 5'h00, monitor_gate)
        // Writes to status and unmapped places change nothing
        wr(2'h2, 16'hFFFF);
        wr(2'h3, 16'hFFFF);
        rd(2'h3, 16'h0000, "unmapped");
        rd(2'h0, 16'h0001, "gate kept");
        rd(2'h1, 16'h0005, "misc kept");
        // Memory clock back on before any memory access
        wr(2'h0, 16'h0000);
        // Measuring clock select and phase share
        wr(2'h1, 16'h0405);
        rd(2'h1, 16'h0405, "misc los");
        `CHK("nvm released", 1'b0, nvm_interface_gate)
        `CHK("los select", 1'b1, los_clk_sel)
        `CHK("share off", 1'b0, ssc_phase_share)
        wr(2'h1, 16'h0025);
        settle(1);
        `CHK("los select", 1'b0, los_clk_sel)
        `CHK("share on", 1'b1, ssc_phase_share)
        // Every mode code, inputs set apart to show independence; no pin edge yet
        for (int m = 0; m < 4; m++) begin
            wr(2'h1, 16'h0005 | 16'(m << 8) | 16'((3 - m) << 3));
            settle(3);
            chk_fo(m == 0, m == 3);
        end
        // Automatic mode: choice taken at the pin's rising edge only
        wr(2'h1, 16'h010D);
        los_one = 1'b1;
        settle(3);
        chk_fo(1'b0, 1'b0);
        pcie_reset_zero_n = 1'b1;
        pcie_reset_one_n  = 1'b1;
        settle(3);
        chk_fo(1'b1, 1'b0);
        los_zero = 1'b1;
        los_one  = 1'b0;
        settle(3);
        chk_fo(1'b1, 1'b0);
        pcie_reset_zero_n = 1'b0;
        pcie_reset_one_n  = 1'b0;
        settle(1);
        pcie_reset_zero_n = 1'b1;
        pcie_reset_one_n  = 1'b1;
        settle(3);
        chk_fo(1'b0, 1'b1);
        // Startup hold, every startup code, group seven exempt
        wr(2'h1, 16'h0005);
        startup_active = 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(2'h1, 16'h0005 | 16'(s << 6));
            settle(3);
            `CHK("drv hold", drv_exp(1'b1, 2'(s), 1'b0), out_drv_en)
        end
        apll_lock = 1'b1;
        settle(3);
        `CHK("drv locked", 12'hFFF, out_drv_en)
        {startup_active, apll_lock} = 2'b00;
        settle(3);
        `CHK("drv run", 12'hFFF, out_drv_en)
        // Second reset in mid-run returns all defaults
        do_reset();
        settle(3);
        chk_fo(1'b0, 1'b0);
        print_verdict();
    end
endmodule
